// [inc/ifs_cfg.svh]
// constants of the instruction fetch sequencer
// assumes inclusion by the core file only
`ifndef IFS_CFG_SVH
`define IFS_CFG_SVH

`define IFS_PC_W          10
`define IFS_LOW_W         8
`define IFS_INSTR_W       14
`define IFS_STACK_DEPTH   4
`define IFS_RESET_VEC     10'h000
`define IFS_EXT_VEC       10'h004
`define IFS_TMR_VEC       10'h008
`define IFS_PC_STEP       10'h001
`define IFS_NOP_WORD      14'h0000
`define IFS_PTRLO_IDX     8'h06
`define IFS_STAT_IDX      8'h20
`define IFS_IDX_TO_BYTE   4
`define IFS_ADDR_W        8
`define IFS_DATA_W        32
`define IFS_CLK_MHZ       20

`endif

// [inc/ifs_pkg.sv]
// types shared by the instruction fetch sequencer
// assumes ifs_cfg.svh is on the include path
package ifs_pkg;
  // four non-overlapping phases of one instruction cycle
  typedef enum logic [1:0] {IFS_PH1, IFS_PH2, IFS_PH3, IFS_PH4} ifs_phase_t;
  // source of the next counter value at a cycle boundary
  typedef enum logic [2:0] {
    IFS_SEL_SEQ, IFS_SEL_LOW, IFS_SEL_POP, IFS_SEL_CALL,
    IFS_SEL_JUMP, IFS_SEL_SKIP, IFS_SEL_IRQ
  } ifs_sel_t;
endpackage

// [core/ifs_core.sv]
// instruction fetch sequencer: phases, fetch pipeline, counter, return stack
// assumes rom, datapath and bus master all run on clk_i
`timescale 1ns/10ps
`include "ifs_cfg.svh"

module ifs_core
  import ifs_pkg::*;
#(
  parameter int PC_W        = `IFS_PC_W,
  parameter int INSTR_W     = `IFS_INSTR_W,
  parameter int STACK_DEPTH = `IFS_STACK_DEPTH
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // program rom
  output logic [PC_W-1:0]             rom_addr_o,
  input  wire logic [INSTR_W-1:0]     rom_data_i,
  // decode / execute datapath
  output logic [INSTR_W-1:0]          instr_o,
  output logic                        instr_valid_o,
  output logic                        dummy_o,
  output logic [1:0]                  phase_o,
  input  wire logic                   jump_i,
  input  wire logic                   call_i,
  input  wire logic                   sub_return_i,
  input  wire logic                   int_return_i,
  input  wire logic                   skip_i,
  input  wire logic [PC_W-1:0]        target_i,
  input  wire logic                   int_en_i,
  input  wire logic                   ext_int_req_i,
  input  wire logic                   tmr_int_req_i,
  output logic                        ext_int_ack_o,
  output logic                        tmr_int_ack_o,
  // avalon-mm slave
  input  wire logic [`IFS_ADDR_W-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [`IFS_DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic [`IFS_DATA_W-1:0]      avs_readdata_o,
  output logic                        avs_waitrequest_o
);

  // ****************************************
  // elaboration checks
  // ****************************************
  localparam int LOW_W = `IFS_LOW_W;
  localparam int SP_W  = $clog2(STACK_DEPTH);
  initial begin
    if (PC_W <= LOW_W || PC_W < 4) $error("ifs_core: PC_W must exceed the low byte");
    if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) $error("ifs_core: bad STACK_DEPTH");
  end

  // ****************************************
  // state
  // ****************************************
  ifs_phase_t                phase_reg, phase_next;
  logic [PC_W-1:0]           pc_reg, pc_next;
  logic [INSTR_W-1:0]        ir_reg, ir_next;
  logic                      dummy_reg, dummy_next;
  logic                      valid_reg;
  logic                      ext_ack_reg, tmr_ack_reg;
  logic [PC_W-1:0]           stack_reg [STACK_DEPTH];
  logic [SP_W-1:0]           sp_reg;
  logic [SP_W:0]             depth_reg;
  logic                      low_pend_reg;
  logic [LOW_W-1:0]          low_data_reg;
  logic                      wait_reg;
  logic [`IFS_DATA_W-1:0]    rdata_reg;
  ifs_sel_t                  sel;

  // ****************************************
  // decode
  // ****************************************
  localparam logic [SP_W:0] FULL_DEPTH = (SP_W+1)'(STACK_DEPTH);
  wire             boundary   = (phase_reg == IFS_PH4);
  wire             live       = !dummy_reg;
  wire             stack_full = (depth_reg == FULL_DEPTH);
  wire             irq_any    = ext_int_req_i | tmr_int_req_i;
  wire             irq_ok     = live & int_en_i & irq_any & !stack_full;
  wire [SP_W-1:0]  sp_top     = sp_reg - SP_W'(1);
  wire [PC_W-1:0]  pop_addr   = stack_reg[sp_top];
  wire [PC_W-1:0]  irq_vec    = ext_int_req_i ? PC_W'(`IFS_EXT_VEC) : PC_W'(`IFS_TMR_VEC);
  wire [PC_W-1:0]  short_tgt  = {pc_reg[PC_W-1:LOW_W], low_data_reg};
  wire             push       = boundary & (sel == IFS_SEL_CALL || sel == IFS_SEL_IRQ);
  wire             pop        = boundary & (sel == IFS_SEL_POP);
  wire             req        = avs_read_i | avs_write_i;
  wire             done       = req & !wait_reg;
  wire             hit_low    = (avs_address_i == `IFS_ADDR_W'(`IFS_PTRLO_IDX * `IFS_IDX_TO_BYTE));
  wire             hit_stat   = (avs_address_i == `IFS_ADDR_W'(`IFS_STAT_IDX * `IFS_IDX_TO_BYTE));
  wire             low_wr     = done & avs_write_i & hit_low & avs_byteenable_i[0];
  wire [`IFS_DATA_W-1:0] rd_val =
    hit_low  ? `IFS_DATA_W'(pc_reg[LOW_W-1:0]) :
    hit_stat ? `IFS_DATA_W'({depth_reg, dummy_reg, phase_reg}) :
               `IFS_DATA_W'(0);

  assign sel = !boundary                  ? IFS_SEL_SEQ  :
               low_pend_reg               ? IFS_SEL_LOW  :
               live & (sub_return_i | int_return_i) ? IFS_SEL_POP :
               live & call_i              ? IFS_SEL_CALL :
               live & jump_i              ? IFS_SEL_JUMP :
               live & skip_i              ? IFS_SEL_SKIP :
               irq_ok                     ? IFS_SEL_IRQ  : IFS_SEL_SEQ;

  // ****************************************
  // next cycle
  // ****************************************
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      IFS_PH1: phase_next = IFS_PH2;
      IFS_PH2: phase_next = IFS_PH3;
      IFS_PH3: phase_next = IFS_PH4;
      IFS_PH4: phase_next = IFS_PH1;
      default: phase_next = IFS_PH1;
    endcase
  end

  always_comb begin
    pc_next    = pc_reg;
    ir_next    = ir_reg;
    dummy_next = dummy_reg;
    if (boundary) begin
      ir_next    = INSTR_W'(`IFS_NOP_WORD);
      dummy_next = 1'b1;
      case (sel)
        IFS_SEL_LOW:  pc_next = short_tgt;
        IFS_SEL_POP:  pc_next = pop_addr;
        IFS_SEL_CALL: pc_next = target_i;
        IFS_SEL_JUMP: pc_next = target_i;
        IFS_SEL_SKIP: pc_next = pc_reg + PC_W'(`IFS_PC_STEP);
        IFS_SEL_IRQ:  pc_next = irq_vec;
        default: begin
          ir_next    = rom_data_i;
          dummy_next = 1'b0;
          pc_next    = pc_reg + PC_W'(`IFS_PC_STEP);
        end
      endcase
    end
  end

  // ****************************************
  // sequencer registers
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg   <= IFS_PH1;
      pc_reg      <= PC_W'(`IFS_RESET_VEC);
      ir_reg      <= INSTR_W'(`IFS_NOP_WORD);
      dummy_reg   <= 1'b1;
      valid_reg   <= 1'b0;
      ext_ack_reg <= 1'b0;
      tmr_ack_reg <= 1'b0;
    end else begin
      phase_reg   <= phase_next;
      pc_reg      <= pc_next;
      ir_reg      <= ir_next;
      dummy_reg   <= dummy_next;
      valid_reg   <= boundary ? !dummy_next : valid_reg;
      ext_ack_reg <= (sel == IFS_SEL_IRQ) & ext_int_req_i;
      tmr_ack_reg <= (sel == IFS_SEL_IRQ) & !ext_int_req_i;
    end
  end

  // ****************************************
  // return stack
  // ****************************************
  for (genvar e = 0; e < STACK_DEPTH; e++) begin : g_stack
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        stack_reg[e] <= PC_W'(`IFS_RESET_VEC);
      end else if (push && sp_reg == SP_W'(e)) begin
        stack_reg[e] <= pc_reg;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_reg    <= '0;
      depth_reg <= '0;
    end else if (push) begin
      sp_reg    <= sp_reg + SP_W'(1);
      depth_reg <= stack_full ? depth_reg : depth_reg + (SP_W+1)'(1);
    end else if (pop) begin
      sp_reg    <= sp_top;
      depth_reg <= (depth_reg == '0) ? depth_reg : depth_reg - (SP_W+1)'(1);
    end
  end

  // ****************************************
  // avalon slave
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg     <= 1'b1;
      rdata_reg    <= '0;
      low_pend_reg <= 1'b0;
      low_data_reg <= '0;
    end else begin
      wait_reg     <= !(req & wait_reg);
      rdata_reg    <= (req & wait_reg) ? rd_val : rdata_reg;
      low_pend_reg <= low_wr | (low_pend_reg & !(sel == IFS_SEL_LOW));
      low_data_reg <= low_wr ? avs_writedata_i[LOW_W-1:0] : low_data_reg;
    end
  end

  assign rom_addr_o        = pc_reg;
  assign instr_o           = ir_reg;
  assign instr_valid_o     = valid_reg;
  assign dummy_o           = dummy_reg;
  assign phase_o           = phase_reg;
  assign ext_int_ack_o     = ext_ack_reg;
  assign tmr_int_ack_o     = tmr_ack_reg;
  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = wait_reg;

  // ****************************************
  // assertions
  // ****************************************
  property p_phase_cycle;
    @(posedge clk_i) disable iff (!rst_n_i)
      phase_reg == IFS_PH1 |=> phase_reg == IFS_PH2 ##1 phase_reg == IFS_PH3
        ##1 phase_reg == IFS_PH4 ##1 phase_reg == IFS_PH1;
  endproperty
  a_phase_cycle: assert property (p_phase_cycle) else $error("phase order broken");

  property p_pc_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      !boundary |=> $stable(pc_reg) && $stable(ir_reg);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("counter moved mid cycle");

  property p_seq_fetch;
    @(posedge clk_i) disable iff (!rst_n_i)
      boundary && sel == IFS_SEL_SEQ |=>
        pc_reg == $past(pc_reg) + PC_W'(1) && ir_reg == $past(rom_data_i) && !dummy_reg;
  endproperty
  a_seq_fetch: assert property (p_seq_fetch) else $error("sequential fetch wrong");

  property p_xfer_dummy;
    @(posedge clk_i) disable iff (!rst_n_i)
      boundary && sel != IFS_SEL_SEQ |=> dummy_reg && ir_reg == INSTR_W'(`IFS_NOP_WORD)
        ##4 (!dummy_reg || $past(sel == IFS_SEL_LOW));
  endproperty
  a_xfer_dummy: assert property (p_xfer_dummy) else $error("dummy cycle missing");

  property p_skip;
    @(posedge clk_i) disable iff (!rst_n_i)
      boundary && sel == IFS_SEL_SKIP |=> pc_reg == $past(pc_reg) + PC_W'(1) && dummy_reg;
  endproperty
  a_skip: assert property (p_skip) else $error("skip not handled");

  property p_short_jump;
    @(posedge clk_i) disable iff (!rst_n_i)
      boundary && low_pend_reg |=>
        pc_reg == {$past(pc_reg[PC_W-1:LOW_W]), $past(low_data_reg)};
  endproperty
  a_short_jump: assert property (p_short_jump) else $error("short jump left page");

  property p_irq_vec;
    @(posedge clk_i) disable iff (!rst_n_i)
      boundary && sel == IFS_SEL_IRQ |=>
        pc_reg == ($past(ext_int_req_i) ? PC_W'(`IFS_EXT_VEC) : PC_W'(`IFS_TMR_VEC))
        && (ext_ack_reg ^ tmr_ack_reg);
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("bad interrupt vector");

  property p_full_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      stack_full |-> sel != IFS_SEL_IRQ;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("irq taken on full stack");

  property p_call_ret;
    @(posedge clk_i) disable iff (!rst_n_i)
      boundary && sel == IFS_SEL_POP |=> pc_reg == $past(pop_addr) && sp_reg == $past(sp_top);
  endproperty
  a_call_ret: assert property (p_call_ret) else $error("return address wrong");

  property p_bus_answer;
    @(posedge clk_i) disable iff (!rst_n_i)
      req && wait_reg |=> !wait_reg ##1 wait_reg;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  c_call:  cover property (@(posedge clk_i) disable iff (!rst_n_i) push && sel == IFS_SEL_CALL);
  c_irq:   cover property (@(posedge clk_i) disable iff (!rst_n_i) ext_ack_reg);
  c_skip:  cover property (@(posedge clk_i) disable iff (!rst_n_i) sel == IFS_SEL_SKIP);
  c_low:   cover property (@(posedge clk_i) disable iff (!rst_n_i) sel == IFS_SEL_LOW);
  c_full:  cover property (@(posedge clk_i) disable iff (!rst_n_i) stack_full && irq_any);

endmodule // ifs_core

// [verification/ifs_rom_model.sv]
// program rom model for the fetch sequencer bench
// assumes a combinational read, always selected
`timescale 1ns/10ps
module ifs_rom_model (
  input  wire logic [9:0]  addr_i,
  output logic      [13:0] data_o
);
  // *****************
  // rom contents
  // *****************
  assign data_o = {4'h3, addr_i};
endmodule // ifs_rom_model

// [verification/test_instruction_fetch_sequencer.sv]
// self-checking bench for the instruction fetch sequencer
// assumes ifs_pkg compiled first; bench plays datapath and bus master
`timescale 1ns/10ps
module test_instruction_fetch_sequencer
  import ifs_pkg::*;
;
  // *****************
  // signals
  // *****************
  localparam logic [4:0] JMP = 5'h10, CAL = 5'h08, SRT = 5'h04, RTI = 5'h02, SKP = 5'h01;
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [9:0]  rom_addr_o;
  logic [13:0] rom_data_i;
  logic [13:0] instr_o;
  logic        instr_valid_o, dummy_o, ext_ack, tmr_ack, waitreq;
  logic [1:0]  phase_o;
  logic [4:0]  ctl     = 5'h00;
  logic [9:0]  target  = 10'h000;
  logic        int_en  = 1'b0;
  logic        ext_req = 1'b0;
  logic        tmr_req = 1'b0;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  be      = 4'hf;
  logic [31:0] rdata, q;
  int          err_count = 0;
  int          n_checks  = 0;

  always #25 clk_i = ~clk_i;

  ifs_core uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
    .instr_o(instr_o), .instr_valid_o(instr_valid_o), .dummy_o(dummy_o), .phase_o(phase_o),
    .jump_i(ctl[4]), .call_i(ctl[3]), .sub_return_i(ctl[2]), .int_return_i(ctl[1]),
    .skip_i(ctl[0]),
    .target_i(target), .int_en_i(int_en), .ext_int_req_i(ext_req), .tmr_int_req_i(tmr_req),
    .ext_int_ack_o(ext_ack), .tmr_int_ack_o(tmr_ack), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq)
  );

  ifs_rom_model rom (.addr_i(rom_addr_o), .data_o(rom_data_i));

  // *****************
  // tasks
  // *****************
  function automatic logic [13:0] rom_word(input logic [9:0] a);
    return {4'h3, a};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] e);
    @(posedge clk_i);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= e;
    do @(posedge clk_i); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // one instruction cycle: controls held over phase 4, then the next cycle checked
  task automatic go(input logic [4:0] c, input logic [9:0] t, input logic d,
                    input logic [9:0] a);
    do @(negedge clk_i); while (phase_o !== 2'd2);
    @(posedge clk_i);
    ctl <= c;
    target <= t;
    @(posedge clk_i);
    ctl <= 5'h00;
    @(negedge clk_i);
    chk(dummy_o, d);
    chk(instr_valid_o, !d);
    chk(rom_addr_o, a);
    chk(instr_o, d ? 14'h0000 : rom_word(a - 10'h001));
  endtask

  // *****************
  // tests
  // *****************
  initial begin
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk(rom_addr_o, 10'h000);
    chk(dummy_o, 1'b1);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    go(5'h00, 10'h000, 1'b0, 10'h001);
    for (int k = 1; k <= 4; k++) begin
      @(negedge clk_i);
      chk(phase_o, k % 4);
    end
    bus(1'b0, 8'h40, 32'h0, 4'hf);
    chk(q, 32'h0000_0000);
    go(5'h00, 10'h000, 1'b0, 10'h004);
    go(JMP, 10'h2f0, 1'b1, 10'h2f0);
    go(JMP, 10'h100, 1'b0, 10'h2f1);
    go(SKP, 10'h000, 1'b1, 10'h2f2);
    go(5'h00, 10'h000, 1'b0, 10'h2f3);
    go(CAL, 10'h155, 1'b1, 10'h155);
    go(SRT, 10'h000, 1'b0, 10'h156);
    go(SRT, 10'h000, 1'b1, 10'h2f3);
    go(5'h00, 10'h000, 1'b0, 10'h2f4);
    bus(1'b0, 8'h18, 32'h0, 4'hf);
    chk(q[7:0], 8'hf4);
    bus(1'b1, 8'h18, 32'h0000_0010, 4'hf);
    bus(1'b1, 8'h18, 32'h0000_0033, 4'he);
    go(5'h00, 10'h000, 1'b0, 10'h211);
    @(posedge clk_i);
    ext_req <= 1'b1;
    go(5'h00, 10'h000, 1'b0, 10'h212);
    @(posedge clk_i);
    int_en <= 1'b1;
    go(5'h00, 10'h000, 1'b1, 10'h004);
    chk(ext_ack, 1'b1);
    @(posedge clk_i);
    ext_req <= 1'b0;
    go(5'h00, 10'h000, 1'b0, 10'h005);
    @(posedge clk_i);
    tmr_req <= 1'b1;
    go(5'h00, 10'h000, 1'b1, 10'h008);
    chk(tmr_ack, 1'b1);
    @(posedge clk_i);
    tmr_req <= 1'b0;
    go(5'h00, 10'h000, 1'b0, 10'h009);
    go(RTI, 10'h000, 1'b1, 10'h005);
    go(5'h00, 10'h000, 1'b0, 10'h006);
    for (int i = 0; i < 3; i++) begin
      go(CAL, 10'h300 + 10'(i * 16), 1'b1, 10'h300 + 10'(i * 16));
      go(5'h00, 10'h000, 1'b0, 10'h301 + 10'(i * 16));
    end
    bus(1'b0, 8'h80, 32'h0, 4'hf);
    chk(q, 32'h0000_0021);
    @(posedge clk_i);
    ext_req <= 1'b1;
    go(5'h00, 10'h000, 1'b0, 10'h323);
    go(SRT, 10'h000, 1'b1, 10'h311);
    go(5'h00, 10'h000, 1'b0, 10'h312);
    go(5'h00, 10'h000, 1'b1, 10'h004);
    chk(ext_ack, 1'b1);
    report_and_stop();
  end

  initial begin
    repeat (4000) @(posedge clk_i);
    err_count++;
    report_and_stop();
  end
endmodule // test_instruction_fetch_sequencer
